// [logic/idc_pkg.sv]
// idc_pkg: shared constants and carriers for the interrupt disable counter
// assumes: one instruction-cycle clock, synchronous active-high reset
package idc_pkg;

   // ****************************************************************
   // widths and levels
   // ****************************************************************
   localparam int            IDC_CNT_W      = 14;
   localparam int            IDC_LVL_W      = 3;
   localparam int            IDC_NSRC       = 8;
   localparam int            IDC_SRC_W      = 3;
   localparam logic [13:0]   IDC_CNT_ZERO   = 14'h0000;
   localparam logic [13:0]   IDC_CNT_ONE    = 14'h0001;
   localparam logic [2:0]    IDC_LVL_TOP    = 3'h7;
   localparam logic [2:0]    IDC_LVL_NONE   = 3'h0;
   localparam logic [7:0]    IDC_STATUS_RST = 8'h00;
   localparam int            IDC_IPL_LSB    = 5;
   localparam int            IDC_IPL_MSB    = 7;
   // hazard window after a priority, enable or flag change
   localparam int            IDC_HAZ_MIN    = 2;
   localparam int            IDC_HAZ_MAX    = 4;
   localparam logic [2:0]    IDC_HAZ_LEN    = 3'h4;

   // ****************************************************************
   // carriers
   // ****************************************************************
   // one mask-instruction or count-register write from the core
   typedef struct packed {
      logic                  mask_instr;
      logic                  cnt_write;
      logic [13:0]           count;
   } idc_cmd_s;

   // one interrupt source
   typedef struct packed {
      logic                  flag;
      logic                  enable;
      logic [2:0]            prio;
   } idc_src_s;

   typedef enum logic [1:0] {
      IDC_ST_OPEN  = 2'b00,
      IDC_ST_MASK  = 2'b01
   } idc_state_e;

endpackage : idc_pkg

// [logic/idc_arbiter.sv]
// idc_arbiter: picks the highest-priority acceptable source
// assumes: purely combinational request vector from the controller
`timescale 1ns/1ns
module idc_arbiter
   import idc_pkg::*;
(
   // requests
   input  wire idc_src_s [IDC_NSRC-1:0] src_i,
   input  wire logic [2:0]              cpu_ipl_i,
   input  wire logic                    mask_active_i,
   // choice
   output logic                         hit_o,
   output logic [IDC_SRC_W-1:0]         id_o,
   output logic [2:0]                   lvl_o
);

   logic [IDC_NSRC-1:0] ok;

   // ****************************************************************
   // per-source acceptance
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < IDC_NSRC; g++) begin : g_ok
         // flag, enable, above cpu level, and under the counter mask only at level 7
         assign ok[g] = src_i[g].flag && src_i[g].enable
                     && (src_i[g].prio > cpu_ipl_i)
                     && !(mask_active_i && src_i[g].prio != IDC_LVL_TOP);
      end
   endgenerate

   // highest level wins, lowest index breaks ties
   always_comb begin
      hit_o = 1'b0;
      id_o  = '0;
      lvl_o = IDC_LVL_NONE;
      for (int i = IDC_NSRC - 1; i >= 0; i--) begin
         if (ok[i] && (!hit_o || src_i[i].prio >= lvl_o)) begin
            hit_o = 1'b1;
            id_o  = IDC_SRC_W'(i);
            lvl_o = src_i[i].prio;
         end
      end
   end

endmodule : idc_arbiter

// [logic/idc_ctrl.sv]
// idc_ctrl: interrupt masking counter and acceptance for the core
// assumes: core signals are synchronous, one pulse per completed instruction
`timescale 1ns/1ns
module idc_ctrl
   import idc_pkg::*;
(
   // clock and reset
   input  wire logic                    clock_i,
   input  wire logic                    reset_i,
   // core side
   input  wire idc_cmd_s                cmd_i,
   input  wire logic                    status_we_i,
   input  wire logic [7:0]              status_i,
   input  wire logic                    src_cfg_chg_i,
   input  wire logic                    ack_i,
   // sources
   input  wire idc_src_s [IDC_NSRC-1:0] src_i,
   // results
   output logic                         irq_o,
   output logic [IDC_SRC_W-1:0]         irq_id_o,
   output logic [2:0]                   irq_lvl_o,
   output logic [IDC_CNT_W-1:0]         mask_count_reg_o,
   output logic                         mask_active_o,
   output logic                         hazard_o,
   output logic [7:0]                   core_status_reg_o
);

   logic [IDC_CNT_W-1:0] cnt_q;
   logic [IDC_CNT_W-1:0] cnt_d;
   idc_state_e           st_q;
   logic [7:0]           status_q;
   logic [2:0]           haz_q;
   logic                 hit;
   logic [IDC_SRC_W-1:0] id;
   logic [2:0]           lvl;
   logic [2:0]           cpu_ipl;

   // ****************************************************************
   // mask counter
   // ****************************************************************
   // a load always re-arms the mask, also on the zero cycle, unlike the flawed part
   always_comb begin
      cnt_d = cnt_q;
      if (cmd_i.mask_instr) begin
         cnt_d = cmd_i.count;
      end else if (cmd_i.cnt_write) begin
         cnt_d = cmd_i.count;
      end else if (cnt_q != IDC_CNT_ZERO) begin
         cnt_d = cnt_q - IDC_CNT_ONE;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         cnt_q <= IDC_CNT_ZERO;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // state follows counter; the instruction's own cycle also masks
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         st_q <= IDC_ST_OPEN;
      end else begin
         case (st_q)
            IDC_ST_OPEN: begin
               if (cnt_d != IDC_CNT_ZERO) st_q <= IDC_ST_MASK;
            end
            IDC_ST_MASK: begin
               if (cnt_d == IDC_CNT_ZERO) st_q <= IDC_ST_OPEN;
            end
            default: st_q <= IDC_ST_OPEN;
         endcase
      end
   end

   // mask in the issuing cycle plus n counted cycles: n+1 in all
   assign mask_active_o = cmd_i.mask_instr || (st_q == IDC_ST_MASK);
   assign mask_count_reg_o = cnt_q;

   // ****************************************************************
   // cpu status and hazard window
   // ****************************************************************
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         status_q <= IDC_STATUS_RST;
      end else if (status_we_i) begin
         status_q <= status_i;
      end
   end

   assign cpu_ipl = status_q[IDC_IPL_MSB:IDC_IPL_LSB];
   assign core_status_reg_o = status_q;

   // flags cycles after a change where acceptance would be unsafe
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         haz_q <= 3'h0;
      end else if (status_we_i || src_cfg_chg_i) begin
         haz_q <= IDC_HAZ_LEN;
      end else if (haz_q != 3'h0) begin
         haz_q <= haz_q - 3'h1;
      end
   end

   // hold off acceptance while the window is open, whether masked or not
   // the change cycle itself also holds off: the arbiter still sees the old
   // level or setting there, so a request launched then would slip through
   // trade-off: acceptance is held one cycle longer than the bare window
   assign hazard_o = status_we_i || src_cfg_chg_i || (haz_q != 3'h0);

   // ****************************************************************
   // acceptance
   // ****************************************************************
   idc_arbiter idc_arbiter_i (
      .src_i         (src_i),
      .cpu_ipl_i     (cpu_ipl),
      .mask_active_i (mask_active_o),
      .hit_o         (hit),
      .id_o          (id),
      .lvl_o         (lvl)
   );

   // registered request; hazard window suppresses it instead of trapping
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         irq_o     <= 1'b0;
         irq_id_o  <= '0;
         irq_lvl_o <= IDC_LVL_NONE;
      end else begin
         irq_o     <= hit && !hazard_o && !ack_i;
         irq_id_o  <= id;
         irq_lvl_o <= lvl;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   load_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
      cmd_i.mask_instr && cmd_i.count != IDC_CNT_ZERO |=> mask_active_o)
      else $error("mask not re-armed after load");
   count_down_a: assert property (@(posedge clock_i) disable iff (reset_i)
      cnt_q != IDC_CNT_ZERO && !cmd_i.mask_instr && !cmd_i.cnt_write
      |=> cnt_q == $past(cnt_q) - IDC_CNT_ONE)
      else $error("counter did not decrement");
   mask_len_a: assert property (@(posedge clock_i) disable iff (reset_i)
      cmd_i.mask_instr && cmd_i.count == 14'h0003
      ##1 (!cmd_i.mask_instr && !cmd_i.cnt_write)[*4]
      |-> $past(mask_active_o) && !mask_active_o)
      else $error("mask length is not n plus one");
   reload_a: assert property (@(posedge clock_i) disable iff (reset_i)
      st_q == IDC_ST_MASK && cmd_i.mask_instr |=> cnt_q == $past(cmd_i.count))
      else $error("reload lost");
   lvl7_pass_a: assert property (@(posedge clock_i) disable iff (reset_i)
      irq_o && $past(mask_active_o) |-> irq_lvl_o == IDC_LVL_TOP)
      else $error("masked level accepted");
   ipl_max_a: assert property (@(posedge clock_i) disable iff (reset_i)
      $past(cpu_ipl) == IDC_LVL_TOP |-> !irq_o)
      else $error("interrupt past top cpu level");
   // the winner index is taken from the cycle the request was launched in
   accept_a: assert property (@(posedge clock_i) disable iff (reset_i)
      irq_o |-> $past(src_i[id].flag && src_i[id].enable
                      && src_i[id].prio > cpu_ipl))
      else $error("unqualified source accepted");
   hazard_a: assert property (@(posedge clock_i) disable iff (reset_i)
      status_we_i |=> !irq_o ##1 !irq_o ##1 !irq_o ##1 !irq_o)
      else $error("accept inside hazard window");
   cfg_hazard_a: assert property (@(posedge clock_i) disable iff (reset_i)
      src_cfg_chg_i |=> !irq_o ##1 !irq_o ##1 !irq_o ##1 !irq_o)
      else $error("accept inside config hazard window");
   haz_len_a: assert property (@(posedge clock_i) disable iff (reset_i)
      status_we_i || src_cfg_chg_i |=> haz_q == IDC_HAZ_LEN)
      else $error("hazard window not opened");
   // a restore must land exactly, or nested masked regions come apart
   restore_a: assert property (@(posedge clock_i) disable iff (reset_i)
      cmd_i.cnt_write && !cmd_i.mask_instr |=> cnt_q == $past(cmd_i.count))
      else $error("count restore lost");
   state_sync_a: assert property (@(posedge clock_i) disable iff (reset_i)
      (st_q == IDC_ST_MASK) == (cnt_q != IDC_CNT_ZERO))
      else $error("mask state and counter disagree");
   ack_drop_a: assert property (@(posedge clock_i) disable iff (reset_i)
      ack_i |=> !irq_o)
      else $error("request held through acknowledge");
   lvl_nonzero_a: assert property (@(posedge clock_i) disable iff (reset_i)
      irq_o |-> irq_lvl_o != IDC_LVL_NONE)
      else $error("level zero source accepted");

endmodule : idc_ctrl

// [verification/idc_core_model.sv]
// idc_core_model: stand-in for the core and the interrupt sources
// assumes: bench sets the controls just after each rising edge
`timescale 1ns/1ns
module idc_core_model
   import idc_pkg::*;
(
   // controls from the bench, and the request from the block
   input  wire logic                    on_i,
   input  wire logic                    en_i,
   input  wire logic [2:0]              lvl_i,
   input  wire logic                    ack_en_i,
   input  wire logic                    irq_i,
   // towards the block
   output idc_src_s [IDC_NSRC-1:0]      src_o,
   output logic                         ack_o
);
   // one live source at index 2; idle sources stay fully cleared
   always_comb begin
      src_o    = '0;
      src_o[2] = '{flag: on_i, enable: en_i, prio: lvl_i};
   end
   // core takes a request as soon as the bench allows it
   assign ack_o = irq_i & ack_en_i;
endmodule : idc_core_model

// [verification/interrupt_disable_counter_bench.sv]
// interrupt_disable_counter_bench: self-checking bench for idc_ctrl
// assumes: idc_core_model drives sources and acknowledge
`timescale 1ns/1ns
module interrupt_disable_counter_bench
   import idc_pkg::*;
;
   logic                    clock_i, reset_i, swe, chg, on, en, ack_en, ack, irq, act, haz;
   logic [7:0]              status, sr;
   logic [2:0]              lvl, id, ilvl;
   logic [13:0]             cnt;
   idc_cmd_s                cmd;
   idc_src_s [IDC_NSRC-1:0] src;
   int                      err_count, check_count;

   idc_ctrl idc_ctrl_i (.clock_i(clock_i), .reset_i(reset_i), .cmd_i(cmd),
      .status_we_i(swe), .status_i(status), .src_cfg_chg_i(chg), .ack_i(ack),
      .src_i(src), .irq_o(irq), .irq_id_o(id), .irq_lvl_o(ilvl),
      .mask_count_reg_o(cnt), .mask_active_o(act), .hazard_o(haz),
      .core_status_reg_o(sr));
   idc_core_model idc_core_model_i (.on_i(on), .en_i(en), .lvl_i(lvl),
      .ack_en_i(ack_en), .irq_i(irq), .src_o(src), .ack_o(ack));

   // 8 ns instruction clock
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   task automatic check(input logic [13:0] seen, input logic [13:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // inputs always move 1 ns after the edge
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : step

   // one cycle of core commands, mask flag and counter judged mid-cycle
   task automatic cyc(input logic [1:0] m, input logic [13:0] n, input logic a,
                      input logic [13:0] c);
      cmd = '{mask_instr: m[1], cnt_write: m[0], count: n};
      #1;
      check(act, a);
      check(cnt, c);
      step(1);
   endtask : cyc

   // set the live source, then judge the request one edge later
   task automatic probe(input logic f, input logic e, input logic [2:0] l, input logic x);
      on = f;
      en = e;
      lvl = l;
      step(1);
      check(irq, x);
   endtask : probe

   task automatic wr_status(input logic [7:0] v);
      status = v;
      swe = 1'b1;
      step(1);
      swe = 1'b0;
      step(6);
   endtask : wr_status

   task automatic test_count;
      cyc(2'b10, 14'h0003, 1, 0);
      cyc(2'b00, 0, 1, 3);
      cyc(2'b00, 0, 1, 2);
      cyc(2'b00, 0, 1, 1);
      cyc(2'b00, 0, 0, 0);
      cyc(2'b10, 14'h0002, 1, 0);
      cyc(2'b00, 0, 1, 2);
      cyc(2'b10, 14'h0002, 1, 1);
      cyc(2'b00, 0, 1, 2);
      cyc(2'b00, 0, 1, 1);
      cyc(2'b10, 14'h0001, 1, 0);
      cyc(2'b00, 0, 1, 1);
      cyc(2'b01, 14'h0001, 0, 0);
      cyc(2'b11, 14'h0002, 1, 1);
      cyc(2'b00, 0, 1, 2);
      cyc(2'b00, 0, 1, 1);
      cyc(2'b00, 0, 0, 0);
      $display("count test done");
   endtask : test_count

   task automatic test_accept;
      probe(1, 1, 3'h3, 1);
      check(id, 2);
      check(ilvl, 3);
      probe(1, 0, 3'h3, 0);
      probe(0, 1, 3'h3, 0);
      probe(1, 1, 3'h0, 0);
      cmd = '{mask_instr: 1'b1, cnt_write: 1'b0, count: 14'h0006};
      step(1);
      cmd = '0;
      probe(1, 1, 3'h6, 0);
      probe(1, 1, 3'h7, 1);
      probe(1, 1, 3'h1, 0);
      step(6);
      wr_status(8'he0);
      check(sr, 8'he0);
      probe(1, 1, 3'h7, 0);
      wr_status(8'h40);
      probe(1, 1, 3'h3, 1);
      probe(1, 1, 3'h2, 0);
      wr_status(8'h00);
      $display("accept test done");
   endtask : test_accept

   task automatic test_hazard;
      int i;
      probe(1, 1, 3'h3, 1);
      // software masks first, then changes the source setting
      cmd = '{mask_instr: 1'b1, cnt_write: 1'b0, count: 14'h0004};
      step(1);
      cmd = '0;
      chg = 1'b1;
      step(1);
      chg = 1'b0;
      check(haz, 1);
      for (i = 0; i < 4; i++) begin
         check(irq, 0);
         step(1);
      end
      for (i = 0; i < 8 && irq !== 1'b1; i++) step(1);
      check(irq, 1);
      check(haz, 0);
      ack_en = 1'b1;
      step(1);
      check(irq, 0);
      ack_en = 1'b0;
      $display("hazard test done");
   endtask : test_hazard

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run

   // watchdog well beyond the fewer than a hundred cycles the tests need
   initial begin
      #20000;
      err_count++;
      complete_run();
   end

   // reset for 5 cycles, then the tests in turn
   initial begin
      {reset_i, swe, chg, on, en, ack_en} = 6'b100000;
      status = 8'h00;
      lvl = 3'h0;
      cmd = '0;
      err_count = 0;
      check_count = 0;
      step(5);
      reset_i = 1'b0;
      check({irq, act, haz, sr}, 0);
      test_count();
      test_accept();
      test_hazard();
      complete_run();
   end
endmodule : interrupt_disable_counter_bench
